// file: esio_bcd.sv
// Decoder of the two-digit BCD program number.
`timescale 1ns/1ps
`default_nettype none
module esio_bcd (
   // Selection code
   input wire logic [6:0] code_in,
   // Decoded number
   output logic [6:0] num,
   output logic valid
);
   // Weights 1, 2, 4, 8 on the low digit, 10, 20, 40 on the high one.
   wire logic [6:0] units = {3'h0, code_in[3:0]};
   wire logic [6:0] tens = {4'h0, code_in[6:4]} * 7'h0a;
   assign num = units + tens;
   assign valid = (code_in[3:0] <= 4'h9);
endmodule : esio_bcd
`default_nettype wire

// file: esio_pkg.sv
// Package of offsets, fields, reset values and timing for the start/stop I/O.
package esio_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_KHZ = 100000;
   localparam int READY_DELAY_MS = 2000;
   localparam int MIN_HOLD_MS = 30;
   // ----------------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------------
   localparam int CODE_W = 7;
   localparam int USER_IN_W = 16;
   localparam int USER_OUT_W = 22;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 8;
   localparam int STEP_W = 8;
   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_DEDIO = 8'h04;
   localparam logic [7:0] REG_USER_OUT = 8'h08;
   localparam logic [7:0] REG_LOCAL = 8'h0c;
   localparam logic [7:0] REG_GLOBAL = 8'h10;
   localparam logic [7:0] REG_HOME = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_USER_IN = 8'h1c;
   localparam logic [7:0] REG_STEP = 8'h20;
   // ----------------------------------------------------------------------
   // Command bits, write-one pulses
   // ----------------------------------------------------------------------
   localparam int CMD_END = 0;
   localparam int CMD_ALARM_A_SET = 1;
   localparam int CMD_ALARM_A_CLR = 2;
   // ----------------------------------------------------------------------
   // Dedicated output control bits
   // ----------------------------------------------------------------------
   localparam int DIO_ALARM_EN = 0;
   localparam int DIO_ALARM_VAL = 1;
   localparam int DIO_READY_EN = 2;
   localparam int DIO_READY_VAL = 3;
   // ----------------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------------
   localparam int ST_RUN = 0;
   localparam int ST_ESTOP = 1;
   localparam int ST_ALARM = 2;
   localparam int ST_READY = 3;
   localparam int ST_SERVO = 4;
   localparam int ST_INIT = 5;
   localparam int ST_BAD_CODE = 6;
   localparam int ST_ALARM_A = 7;
   localparam int ST_PROG_LSB = 8;
   localparam int ST_STEP_LSB = 16;
   // ----------------------------------------------------------------------
   // Reset and launch values
   // ----------------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [7:0] STEP_FIRST = 8'h01;
endpackage : esio_pkg

// file: esio_seq_model.sv
// Behavioural model of the external sequencer on the start and selection pins.
`timescale 1ns/1ps
`default_nettype none
module esio_seq_model #(
   parameter int WAIT = 8
) (
   // Clock
   input wire logic clk,
   // Commands from the bench
   input wire logic req,
   input wire logic [6:0] num,
   input wire logic no_wait,
   input wire logic raw,
   output var logic busy,
   // Device pins
   input wire logic ready_out,
   output var logic start_in,
   output var logic [6:0] program_select_input
);
   // -------------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------------
   // WAIT stands in for the 30 ms spacing, scaled down so the run stays short.
   // Only start and selection pins exist here, so reserved inputs stay idle.
   int cnt;

   // Binary 0..79 to tens digit in bits 6:4 and units in bits 3:0.
   function automatic logic [6:0] to_code(input logic [6:0] n);
      to_code = {3'(n / 7'd10), 4'(n % 7'd10)};
   endfunction : to_code

   initial
   begin
      busy = 1'b0;
      start_in = 1'b0;
      program_select_input = 7'h00;
      forever
      begin
         @(posedge clk);
         if (req === 1'b1)
         begin
            busy <= 1'b1;
            cnt = 0;
            while (!no_wait && cnt < WAIT)
            begin
               @(posedge clk);
               cnt = (ready_out === 1'b1) ? cnt + 1 : 0;
            end
            // A raw code lets the bench offer a pattern that is no BCD.
            program_select_input <= raw ? num : to_code(num);
            repeat (WAIT) @(posedge clk);
            start_in <= 1'b1;
            repeat (WAIT) @(posedge clk);
            start_in <= 1'b0;
            repeat (WAIT) @(posedge clk);
            busy <= 1'b0;
         end
      end
   end
endmodule : esio_seq_model
`default_nettype wire

// file: esio_sync.sv
// Three-stage input synchroniser with agreement filter per bit.
`timescale 1ns/1ps
`default_nettype none
module esio_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins and filtered levels
   input wire logic [W-1:0] pin_in,
   output var logic [W-1:0] level_q
);
   // ----------------------------------------------------------------------
   // Per-bit chain
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               s1_q <= RST_VAL[i];
               s2_q <= RST_VAL[i];
               s3_q <= RST_VAL[i];
               level_q[i] <= RST_VAL[i];
            end
            else
            begin
               s1_q <= pin_in[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               // A change counts only once two late stages agree.
               if (s2_q == s3_q)
                  level_q[i] <= s3_q;
            end
         end
      end
   endgenerate
endmodule : esio_sync
`default_nettype wire

// file: esio_top.sv
// Dedicated start, emergency stop, alarm and ready supervisor.
`timescale 1ns/1ps
`default_nettype none
module esio_top #(
   parameter int READY_CYCLES = esio_pkg::READY_DELAY_MS * esio_pkg::CLK_KHZ,
   parameter int USER_IN_W = esio_pkg::USER_IN_W,
   parameter int USER_OUT_W = esio_pkg::USER_OUT_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Dedicated and user input pins
   input wire logic start_in,
   input wire logic estop_n_in,
   input wire logic [esio_pkg::CODE_W-1:0] program_select_input,
   input wire logic [USER_IN_W-1:0] user_in,
   // Dedicated and user output pins
   output var logic alarm_out,
   output var logic ready_out,
   output var logic servo_on,
   output var logic [USER_OUT_W-1:0] user_out,
   // Program launch to the execution engine
   output var logic prog_start,
   output var logic [esio_pkg::CODE_W-1:0] prog_num,
   // Register port
   input wire logic [esio_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [esio_pkg::WORD_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output var logic [esio_pkg::WORD_W-1:0] reg_rdata
);
   // ----------------------------------------------------------------------
   // Input conditioning
   // ----------------------------------------------------------------------
   localparam int PIN_W = 2 + esio_pkg::CODE_W + USER_IN_W;
   logic [PIN_W-1:0] pins_f;
   // Stop pin resets low so the block wakes up stopped until the contact
   // is seen closed.
   esio_sync #(
      .W(PIN_W),
      .RST_VAL({PIN_W{1'b0}})
   ) u_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_in({user_in, program_select_input, estop_n_in, start_in}),
      .level_q(pins_f)
   );
   wire logic start_f = pins_f[0];
   wire logic estop_act = ~pins_f[1];
   wire logic [esio_pkg::CODE_W-1:0] code_f = pins_f[2 +: esio_pkg::CODE_W];
   wire logic [USER_IN_W-1:0] uin_f = pins_f[PIN_W-1 -: USER_IN_W];

   logic [6:0] bcd_num;
   logic bcd_ok;
   esio_bcd u_bcd (
      .code_in(code_f),
      .num(bcd_num),
      .valid(bcd_ok)
   );

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic start_prev_q;
   logic [31:0] init_cnt_q;
   logic init_done_q;
   logic run_q;
   logic class_a_q;
   logic bad_code_q;
   logic [esio_pkg::STEP_W-1:0] step_q;
   logic [3:0] dedio_q;
   logic [31:0] local_q;
   logic [31:0] global_q;
   logic [31:0] home_q;

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire logic wr_cmd = reg_wr && (reg_addr == esio_pkg::REG_CMD);
   wire logic wr_dio = reg_wr && (reg_addr == esio_pkg::REG_DEDIO);
   wire logic wr_uout = reg_wr && (reg_addr == esio_pkg::REG_USER_OUT);
   wire logic wr_local = reg_wr && (reg_addr == esio_pkg::REG_LOCAL);
   wire logic wr_glob = reg_wr && (reg_addr == esio_pkg::REG_GLOBAL);
   wire logic wr_home = reg_wr && (reg_addr == esio_pkg::REG_HOME);
   wire logic wr_step = reg_wr && (reg_addr == esio_pkg::REG_STEP);
   wire logic end_cmd = wr_cmd && reg_wdata[esio_pkg::CMD_END];
   wire logic a_set = wr_cmd && reg_wdata[esio_pkg::CMD_ALARM_A_SET];
   wire logic a_clr = wr_cmd && reg_wdata[esio_pkg::CMD_ALARM_A_CLR];

   wire logic start_rise = start_f && !start_prev_q;
   // Each new edge is taken while ready, not stopped and with a valid BCD code, so a second program may follow the first.
   wire logic start_ok = start_rise && ready_out && !estop_act
      && bcd_ok;
   // Stop and the end command both clear run, servo, step, user outputs and the local word.
   wire logic wipe = estop_act || end_cmd;

   wire logic alarm_auto = class_a_q;
   wire logic alarm_d = estop_act || (dedio_q[esio_pkg::DIO_ALARM_EN]
      ? dedio_q[esio_pkg::DIO_ALARM_VAL] : alarm_auto);
   wire logic ready_auto = dedio_q[esio_pkg::DIO_READY_EN]
      ? dedio_q[esio_pkg::DIO_READY_VAL] : init_done_q;
   wire logic ready_d = ready_auto && !alarm_d;

   // ----------------------------------------------------------------------
   // Power-on initialisation timer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         init_cnt_q <= 32'h0;
         init_done_q <= 1'b0;
      end
      else if (!init_done_q)
      begin
         init_cnt_q <= init_cnt_q + 32'h1;
         init_done_q <= (init_cnt_q >= 32'(READY_CYCLES - 1));
      end
   end

   // ----------------------------------------------------------------------
   // Dedicated outputs and launch
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         start_prev_q <= 1'b0;
         alarm_out <= 1'b0;
         ready_out <= 1'b0;
         prog_start <= 1'b0;
         prog_num <= 7'h00;
         bad_code_q <= 1'b0;
         class_a_q <= 1'b0;
      end
      else
      begin
         start_prev_q <= start_f;
         alarm_out <= alarm_d;
         ready_out <= ready_d;
         prog_start <= start_ok;
         if (start_ok)
            prog_num <= bcd_num;
         if (start_rise)
            bad_code_q <= !bcd_ok;
         // A new alarm wins over a clear written in the same cycle.
         if (a_set)
            class_a_q <= 1'b1;
         else if (a_clr)
            class_a_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Program state
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         run_q <= 1'b0;
         servo_on <= 1'b0;
         step_q <= 8'h00;
      end
      else if (wipe)
      begin
         run_q <= 1'b0;
         servo_on <= 1'b0;
         step_q <= 8'h00;
      end
      else if (start_ok)
      begin
         run_q <= 1'b1;
         servo_on <= 1'b1;
         step_q <= esio_pkg::STEP_FIRST;
      end
      else if (wr_step && run_q)
         step_q <= reg_wdata[esio_pkg::STEP_W-1:0];
   end

   // ----------------------------------------------------------------------
   // Software-visible storage
   // ----------------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         dedio_q <= 4'h0;
         user_out <= '0;
         local_q <= esio_pkg::RST_WORD;
         global_q <= esio_pkg::RST_WORD;
         home_q <= esio_pkg::RST_WORD;
      end
      else
      begin
         if (wr_dio)
            dedio_q <= reg_wdata[3:0];
         if (wipe)
         begin
            user_out <= '0;
            local_q <= esio_pkg::RST_WORD;
         end
         else
         begin
            if (wr_uout)
               user_out <= reg_wdata[USER_OUT_W-1:0];
            if (wr_local)
               local_q <= reg_wdata;
         end
         // The end command leaves the home position untouched.
         if (estop_act)
            home_q <= esio_pkg::RST_WORD;
         else if (wr_home)
            home_q <= reg_wdata;
         // Globals see only software writes, never stop or end.
         if (wr_glob)
            global_q <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   wire logic [31:0] status_w = {8'h00, step_q, 1'b0, prog_num,
      class_a_q, bad_code_q, init_done_q, servo_on, ready_out, alarm_out,
      estop_act, run_q};
   // Selection pins stay readable after launch like any user input.
   wire logic [31:0] uin_w = 32'({uin_f, code_f});
   logic [31:0] rd_mux;
   always_comb
   begin
      case (reg_addr)
         esio_pkg::REG_DEDIO: rd_mux = {28'h0, dedio_q};
         esio_pkg::REG_USER_OUT: rd_mux = 32'(user_out);
         esio_pkg::REG_LOCAL: rd_mux = local_q;
         esio_pkg::REG_GLOBAL: rd_mux = global_q;
         esio_pkg::REG_HOME: rd_mux = home_q;
         esio_pkg::REG_STATUS: rd_mux = status_w;
         esio_pkg::REG_USER_IN: rd_mux = uin_w;
         esio_pkg::REG_STEP: rd_mux = {24'h0, step_q};
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         reg_rdata <= 32'h0;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= 32'h0;
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   a_estop_clears_outs: assert property (
      estop_act |=> !servo_on && (user_out == '0) && alarm_out)
      else $error("stop did not clear servo and outputs or raise alarm");
   a_estop_wipes_state: assert property (
      estop_act |=> !run_q && (local_q == 32'h0) && (home_q == 32'h0))
      else $error("stop did not wipe program state");
   a_alarm_kills_ready: assert property (
      alarm_out |-> !ready_out)
      else $error("ready high while alarm high");
   a_class_a_alarm: assert property (
      class_a_q && !dedio_q[esio_pkg::DIO_ALARM_EN] |=> alarm_out)
      else $error("class A alarm not shown");
   a_launch_step_one: assert property (
      start_ok && !wipe |=> run_q && (step_q == 8'h01) && prog_start)
      else $error("launch did not start at step 1");
   a_launch_number: assert property (
      start_ok |=> prog_num == $past(bcd_num))
      else $error("launched number differs from selection");
   a_edge_only: assert property (
      start_f && $past(start_f) |=> !prog_start)
      else $error("held start launched again");
   a_start_gated: assert property (
      start_rise && (!ready_out || estop_act) |=> !prog_start)
      else $error("start taken without ready or during stop");
   a_global_kept: assert property (
      !wr_glob |=> global_q == $past(global_q))
      else $error("global word changed without a write");
   a_end_keeps_home: assert property (
      end_cmd && !estop_act && !wr_home |=> home_q == $past(home_q)
         && !run_q)
      else $error("end command lost home or kept running");
   a_init_ready: assert property (
      !init_done_q && !dedio_q[esio_pkg::DIO_READY_EN] |=> !ready_out)
      else $error("ready before initialisation");

   c_launch: cover property (prog_start);
   c_second_launch: cover property (prog_start ##[1:1000] prog_start);
   c_estop: cover property ($rose(estop_act) && run_q);
   c_end: cover property (end_cmd && run_q);
endmodule : esio_top
`default_nettype wire

// file: tb_external_start_estop_io.sv
// Self-checking bench for the start, stop, alarm and ready supervisor.
`timescale 1ns/1ps
`default_nettype none
module tb_external_start_estop_io;
   // -------------------------------------------------------------------
   // Signals
   // -------------------------------------------------------------------
   localparam int RDY = 50;
   logic clk, sys_rst, estop_n_in, reg_wr, reg_rd, req, no_wait, busy, raw;
   logic alarm_out, ready_out, servo_on, prog_start, start_in;
   logic [15:0] user_in;
   logic [21:0] user_out;
   logic [6:0] prog_num, program_select_input, num;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, rd, uo, gl, hv;
   int mismatches = 0;
   int n_compared = 0;
   int n_pulse = 0;
   int cycles = 0;
   int seed = 49;

   esio_top #(.READY_CYCLES(RDY)) i_dut (.clk(clk), .sys_rst(sys_rst),
      .start_in(start_in), .estop_n_in(estop_n_in),
      .program_select_input(program_select_input), .user_in(user_in),
      .alarm_out(alarm_out), .ready_out(ready_out), .servo_on(servo_on),
      .user_out(user_out), .prog_start(prog_start), .prog_num(prog_num),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   esio_seq_model #(.WAIT(8)) i_seq (.clk(clk), .req(req), .num(num),
      .no_wait(no_wait), .raw(raw), .busy(busy), .ready_out(ready_out),
      .start_in(start_in), .program_select_input(program_select_input));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hang counts as a mismatch and ends the run through the report.
   always @(posedge clk)
   begin
      cycles++;
      if (prog_start === 1'b1) n_pulse++;
      if (cycles == 20000)
      begin
         mismatches++;
         summarize();
      end
   end

   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   function automatic logic [6:0] exp_code(input logic [6:0] n);
      exp_code = {3'(n / 7'd10), 4'(n % 7'd10)};
   endfunction : exp_code

   task automatic check(input logic [31:0] seen, exp, input string msg);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask : rdr

   task automatic wait_ready();
      for (int i = 0; i < 300 && ready_out !== 1'b1; i++) @(posedge clk);
      #1 check(ready_out, 1, "ready");
   endtask : wait_ready

   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle

   // The sequencer runs one whole start; ex decides if a pulse is due.
   task automatic launch(input logic [6:0] n, input logic nw, input int ex);
      int old;
      old = n_pulse;
      num <= n;
      no_wait <= nw;
      req <= 1'b1;
      @(posedge clk);
      req <= 1'b0;
      for (int i = 0; i < 400; i++)
      begin
         @(posedge clk);
         #1;
         if (busy === 1'b0) break;
      end
      check(n_pulse, old + ex, "launch pulses");
      if (ex == 1)
      begin
         check(prog_num, n, "program number");
         check(servo_on, 1, "servo on");
         rdr(esio_pkg::REG_STATUS);
         check(rd[esio_pkg::ST_STEP_LSB +: 8], 1, "step 1");
         check(rd[esio_pkg::ST_RUN], 1, "running");
         check(rd[esio_pkg::ST_BAD_CODE], 0, "code accepted");
         rdr(esio_pkg::REG_USER_IN);
         check(rd[6:0], exp_code(n), "selection as input");
         check(rd[22:7], user_in, "user inputs");
      end
   endtask : launch

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial
   begin
      sys_rst = 1'b1;
      estop_n_in = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      req = 1'b0;
      no_wait = 1'b0;
      raw = 1'b0;
      num = 7'h00;
      user_in = 16'($random(seed));
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check(ready_out, 0, "ready too early");
      wait_ready();
      check(alarm_out, 0, "alarm idle");
      for (int i = 0; i < 6; i++)
         launch((i == 0) ? 7'd0 : (i == 1) ? 7'd79 : 7'({$random(seed)} % 80),
            1'b0, 1);
      // A low digit of ten is no BCD number and must not launch.
      raw <= 1'b1;
      launch(7'h1a, 1'b0, 0);
      raw <= 1'b0;
      rdr(esio_pkg::REG_STATUS);
      check(rd[esio_pkg::ST_BAD_CODE], 1, "bad code flagged");
      wr(esio_pkg::REG_STEP, 32'h0000_002a);
      rdr(esio_pkg::REG_STEP);
      check(rd, 32'h0000_002a, "step while running");
      uo = $random(seed);
      gl = $random(seed);
      wr(esio_pkg::REG_USER_OUT, uo);
      wr(esio_pkg::REG_LOCAL, $random(seed));
      wr(esio_pkg::REG_HOME, $random(seed));
      wr(esio_pkg::REG_GLOBAL, gl);
      settle();
      check(user_out, uo[21:0], "user outputs set");
      @(posedge clk);
      estop_n_in <= 1'b0;
      repeat (8) @(posedge clk);
      #1 check(alarm_out, 1, "stop alarm");
      check(ready_out, 0, "stop ready");
      check(servo_on, 0, "stop servo");
      check(user_out, 0, "stop outputs");
      rdr(esio_pkg::REG_STATUS);
      check(rd[esio_pkg::ST_RUN], 0, "stop halts");
      rdr(esio_pkg::REG_LOCAL);
      check(rd, 0, "stop local");
      rdr(esio_pkg::REG_HOME);
      check(rd, 0, "stop home");
      wr(esio_pkg::REG_STEP, 32'h0000_0033);
      rdr(esio_pkg::REG_STEP);
      check(rd, 0, "step write while stopped");
      launch(7'd5, 1'b1, 0);
      @(posedge clk);
      estop_n_in <= 1'b1;
      wait_ready();
      check(alarm_out, 0, "stop released");
      rdr(esio_pkg::REG_GLOBAL);
      check(rd, gl, "global kept");
      launch(7'({$random(seed)} % 80), 1'b0, 1);
      wr(esio_pkg::REG_CMD, 32'h1 << esio_pkg::CMD_ALARM_A_SET);
      settle();
      check(alarm_out, 1, "class A alarm");
      check(ready_out, 0, "ready under alarm");
      wr(esio_pkg::REG_CMD, 32'h1 << esio_pkg::CMD_ALARM_A_CLR);
      wait_ready();
      wr(esio_pkg::REG_DEDIO, 32'h3);
      settle();
      check(alarm_out, 1, "alarm by software");
      check(ready_out, 0, "ready under soft alarm");
      wr(esio_pkg::REG_DEDIO, 32'h5);
      settle();
      check(alarm_out, 0, "alarm cleared by software");
      check(ready_out, 0, "ready cleared by software");
      launch(7'd3, 1'b1, 0);
      wr(esio_pkg::REG_DEDIO, 32'h0);
      wait_ready();
      hv = $random(seed);
      wr(esio_pkg::REG_USER_OUT, uo);
      wr(esio_pkg::REG_HOME, hv);
      wr(esio_pkg::REG_CMD, 32'h1 << esio_pkg::CMD_END);
      settle();
      check(servo_on, 0, "end servo");
      check(user_out, 0, "end outputs");
      rdr(esio_pkg::REG_HOME);
      check(rd, hv, "end keeps home");
      launch(7'({$random(seed)} % 80), 1'b0, 1);
      wr(8'hfc, $random(seed));
      rdr(8'hfc);
      check(rd, 0, "unmapped read");
      summarize();
   end
endmodule : tb_external_start_estop_io
`default_nettype wire
